// ===== hw/sioe_defines.svh
// Register offsets, field positions and timing counts of the expander controller
`ifndef SIOE_DEFINES_SVH
`define SIOE_DEFINES_SVH
`define SIOE_CTL_OFS 12'h430
`define SIOE_ADR0_OFS 12'h434
`define SIOE_ADR1_OFS 12'h438
`define SIOE_STS_OFS 12'h440
`define SIOE_MSK_OFS 12'h444
`define SIOE_RFR_BIT 24
`define SIOE_TM_BIT 25
`define SIOE_SEL_LSB 26
`define SIOE_SEL_MSB 29
`define SIOE_DONE_BIT 31
`define SIOE_NUM_EXP 5
`define SIOE_SEL_MAX 4'h4
`define SIOE_CLK_MHZ 40
`define SIOE_QTR_NS 50
`define SIOE_QTR_CYC ((`SIOE_QTR_NS * `SIOE_CLK_MHZ + 999) / 1000)
`define SIOE_CMD_IN 8'h00
`define SIOE_CMD_OUT 8'h02
`define SIOE_CMD_CFG 8'h06
`define SIOE_RESP_OKAY 2'h0
`define SIOE_RESP_SLVERR 2'h2
`endif

// ===== hw/sioe_pkg.sv
// Types shared by the expander controller and its byte engine
package sioe_pkg;
  // Bus operations of the byte engine
  typedef enum logic [1:0] {SIOE_OP_START, SIOE_OP_WRITE, SIOE_OP_READ, SIOE_OP_STOP} sioe_op_e;
  // Sequencer states
  typedef enum logic [1:0] {SIOE_IDLE, SIOE_ISSUE, SIOE_WAIT} sioe_st_e;
  // Kinds of expander transaction
  typedef enum logic [1:0] {SIOE_SEQ_OUT, SIOE_SEQ_IN, SIOE_SEQ_CFG} sioe_seq_e;
  // One command for the byte engine
  typedef struct packed {
    sioe_op_e op;
    logic [7:0] data;
    logic last;
  } sioe_cmd_s;
endpackage

// ===== hw/sioe_byte_eng.sv
// SMBus byte engine: start, stop, byte write and byte read on open-drain pins
`timescale 1ns/1ps
`default_nettype none
`include "sioe_defines.svh"
module sioe_byte_eng import sioe_pkg::*; (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic cmd_valid_in, // Command offered
  input wire sioe_cmd_s cmd_in, // Command payload
  output logic cmd_ready_out, // Engine idle
  output logic done_out, // Command finished, pulse
  output logic [7:0] rdata_out, // Byte read
  output logic nack_out, // Write byte not acknowledged, pulse
  input wire logic scl_in, // Clock pin level
  input wire logic sda_in, // Data pin level
  output logic scl_out, // Clock pin drive value
  output logic scl_oe_n_out, // Clock pin enable, low drives
  output logic sda_out, // Data pin drive value
  output logic sda_oe_n_out // Data pin enable, low drives
);
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r; // Pin synchronisers
  logic [6:0] qcnt_r; // Quarter bit timer
  logic [1:0] phase_r; // Quarter within bit
  logic [3:0] bitn_r; // Bit number, 8 is acknowledge
  logic busy_r; // Command under way
  sioe_cmd_s cmd_r; // Command held
  logic [7:0] tx_r; // Bits still to send
  logic tick, step; // Quarter elapsed, quarter may advance
  logic drive_bit; // Data pin pulled low in this bit

  // Two flip-flops on each pin before use
  always_ff @(posedge core_clk_in) begin
    scl_s1_r <= scl_in;
    scl_s2_r <= scl_s1_r;
    sda_s1_r <= sda_in;
    sda_s2_r <= sda_s1_r;
  end

  assign tick = busy_r && (qcnt_r == 7'(`SIOE_QTR_CYC - 1));
  // Hold the high phase while a target stretches the clock
  assign step = tick && !(phase_r == 2'h2 && !scl_s2_r);
  always_comb begin
    if (cmd_r.op == SIOE_OP_WRITE) begin
      drive_bit = (bitn_r < 4'h8) ? !tx_r[7] : 1'b0;
    end else begin
      drive_bit = (bitn_r < 4'h8) ? 1'b0 : !cmd_r.last;
    end
  end

  // Quarter timer, restarts on each tick
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !busy_r || tick) begin
      qcnt_r <= 7'h00;
    end else begin
      qcnt_r <= qcnt_r + 7'h01;
    end
  end

  // Bit sequencing and pin drive
  always_ff @(posedge core_clk_in) begin
    done_out <= 1'b0;
    nack_out <= 1'b0;
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      cmd_ready_out <= 1'b0;
      phase_r <= 2'h0;
      bitn_r <= 4'h0;
      cmd_r <= '0;
      tx_r <= 8'h00;
      rdata_out <= 8'h00;
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (!busy_r) begin
      cmd_ready_out <= 1'b1;
      if (cmd_valid_in && cmd_ready_out) begin
        busy_r <= 1'b1;
        cmd_ready_out <= 1'b0;
        cmd_r <= cmd_in;
        tx_r <= cmd_in.data;
        phase_r <= 2'h0;
        bitn_r <= 4'h0;
      end
    end else if (step) begin
      phase_r <= phase_r + 2'h1;
      case (phase_r)
        2'h0: begin
          // Set data while the clock is low
          case (cmd_r.op)
            SIOE_OP_START: sda_oe_n_out <= 1'b1;
            SIOE_OP_STOP: begin
              scl_oe_n_out <= 1'b0;
              sda_oe_n_out <= 1'b0;
            end
            default: sda_oe_n_out <= !drive_bit;
          endcase
        end
        2'h1: scl_oe_n_out <= 1'b1;
        2'h2: begin
          // Clock is high: start, stop or sample
          case (cmd_r.op)
            SIOE_OP_START: sda_oe_n_out <= 1'b0;
            SIOE_OP_STOP: sda_oe_n_out <= 1'b1;
            default: begin
              if (bitn_r < 4'h8) begin
                rdata_out <= {rdata_out[6:0], sda_s2_r};
              end else if (cmd_r.op == SIOE_OP_WRITE) begin
                nack_out <= sda_s2_r;
              end
            end
          endcase
        end
        default: begin
          if (cmd_r.op != SIOE_OP_STOP) begin
            scl_oe_n_out <= 1'b0;
          end
          if (cmd_r.op == SIOE_OP_START || cmd_r.op == SIOE_OP_STOP || bitn_r == 4'h8) begin
            busy_r <= 1'b0;
            done_out <= 1'b1;
          end else begin
            bitn_r <= bitn_r + 4'h1;
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hw/sioe_ctrl.sv
// Expander controller: AXI4-Lite registers, sequencer and SMBus master
`timescale 1ns/1ps
`default_nettype none
`include "sioe_defines.svh"
module sioe_ctrl import sioe_pkg::*; (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic sticky_rst_n_in, // Reset of sticky fields, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [4:0][15:0] core_out_in, // Core output values per expander
  input wire logic [4:0][15:0] exp_dir_in, // Pin is input when set
  input wire logic scl_in, // SMBus clock pin level
  input wire logic sda_in, // SMBus data pin level
  output logic scl_out, // Clock drive value
  output logic scl_oe_n_out, // Clock enable, low drives
  output logic sda_out, // Data drive value
  output logic sda_oe_n_out, // Data enable, low drives
  output logic irq_out // Interrupt, high while unmasked status set
);
  // Bus slave state
  logic [11:0] aw_addr_r; // Captured write address
  logic aw_got_r, w_got_r; // Address and data held
  logic [31:0] w_data_r; // Captured write data
  logic [3:0] w_strb_r; // Captured byte enables
  logic wr_fire; // Register write happens
  logic [31:0] rd_val; // Read mux output
  logic rd_hit, wr_hit; // Address is mapped
  // Software visible state
  logic tm_r; // Test mode
  logic [3:0] sel_r; // Selected expander
  logic done_r; // Completion flag
  logic [1:0] sts_r, msk_r; // Event status and mask
  logic [6:0] addr_r [`SIOE_NUM_EXP]; // Expander bus addresses, sticky
  logic [15:0] test_r [`SIOE_NUM_EXP]; // Test-mode output values
  logic [15:0] pin_r [`SIOE_NUM_EXP]; // Last known pin state
  logic [4:0] init_pend_r, init_set; // Queued initialisations
  logic rfr_pend_r; // Queued refresh
  // Write decode
  logic ctl_wr, adr0_wr, adr1_wr; // Register selected by write
  logic [3:0] wsel; // Select value in force for this write
  logic wtm; // Test mode in force for this write
  // Sequencer state
  sioe_st_e st_r; // Sequencer state
  sioe_seq_e kind_r; // Transaction kind
  logic [2:0] exp_r; // Expander being served
  logic [3:0] step_r; // Step within transaction
  logic [7:0] rx_lo_r; // First byte read
  sioe_cmd_s cmd_r, step_cmd; // Command held, command of this step
  logic cmd_valid_r; // Command offered to engine
  logic [3:0] last_step; // Final step of this kind
  logic [15:0] out_val; // Outputs for the expander served
  logic done_set; // Completion event
  logic [2:0] init_idx; // Lowest queued initialisation
  // Engine answers
  logic eng_ready, eng_done, eng_nack; // Engine handshake and status
  logic [7:0] eng_rdata; // Engine read byte

  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign ctl_wr = wr_fire && aw_addr_r == `SIOE_CTL_OFS;
  assign adr0_wr = wr_fire && aw_addr_r == `SIOE_ADR0_OFS;
  assign adr1_wr = wr_fire && aw_addr_r == `SIOE_ADR1_OFS;
  assign wr_hit = aw_addr_r == `SIOE_CTL_OFS || aw_addr_r == `SIOE_ADR0_OFS ||
                  aw_addr_r == `SIOE_ADR1_OFS || aw_addr_r == `SIOE_STS_OFS ||
                  aw_addr_r == `SIOE_MSK_OFS;
  assign wsel = w_strb_r[3] ? w_data_r[`SIOE_SEL_MSB:`SIOE_SEL_LSB] : sel_r;
  assign wtm = w_strb_r[3] ? w_data_r[`SIOE_TM_BIT] : tm_r;

  // Write address and data channels, taken in either order
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
        s_axi_awready <= 1'b1;
      end else begin
        s_axi_awready <= !aw_got_r;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
        s_axi_wready <= 1'b1;
      end else begin
        s_axi_wready <= !w_got_r;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SIOE_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `SIOE_RESP_OKAY : `SIOE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; refresh bit and reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `SIOE_CTL_OFS: begin
        rd_val[`SIOE_DONE_BIT] = done_r;
        rd_val[`SIOE_SEL_MSB:`SIOE_SEL_LSB] = sel_r;
        rd_val[`SIOE_TM_BIT] = tm_r;
        rd_val[15:0] = (sel_r <= `SIOE_SEL_MAX) ? pin_r[sel_r[2:0]] : 16'h0000;
      end
      `SIOE_ADR0_OFS: rd_val = {addr_r[3], 1'b0, addr_r[2], 1'b0, addr_r[1], 1'b0, addr_r[0], 1'b0};
      `SIOE_ADR1_OFS: rd_val[7:1] = addr_r[4];
      `SIOE_STS_OFS: rd_val[1:0] = sts_r;
      `SIOE_MSK_OFS: rd_val[1:0] = msk_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel, data one cycle after the address
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SIOE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `SIOE_RESP_OKAY : `SIOE_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // Control fields; completion set wins over its clear
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tm_r <= 1'b0;
      sel_r <= 4'h0;
      done_r <= 1'b0;
    end else begin
      if (ctl_wr && w_strb_r[3]) begin
        tm_r <= w_data_r[`SIOE_TM_BIT];
        sel_r <= w_data_r[`SIOE_SEL_MSB:`SIOE_SEL_LSB];
      end
      done_r <= done_set || (done_r && !(ctl_wr && w_strb_r[3] && w_data_r[`SIOE_DONE_BIT]));
    end
  end

  // Event status and mask; set wins over clear
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sts_r <= 2'h0;
      msk_r <= 2'h0;
      irq_out <= 1'b0;
    end else begin
      sts_r <= {eng_nack, done_set} |
               (sts_r & ~((wr_fire && aw_addr_r == `SIOE_STS_OFS && w_strb_r[0]) ? w_data_r[1:0] : 2'h0));
      if (wr_fire && aw_addr_r == `SIOE_MSK_OFS && w_strb_r[0]) begin
        msk_r <= w_data_r[1:0];
      end
      irq_out <= |(sts_r & msk_r);
    end
  end

  // Per-expander address fields and test data
  genvar k;
  generate
    for (k = 0; k < `SIOE_NUM_EXP; k++) begin : g_exp
      localparam int LANE = k % 4;
      logic fld_wr; // This address field written
      assign fld_wr = ((k < 4) ? adr0_wr : adr1_wr) && w_strb_r[LANE];
      assign init_set[k] = fld_wr;
      // Sticky address, cleared only by the sticky reset
      always_ff @(posedge core_clk_in) begin
        if (!sticky_rst_n_in) begin
          addr_r[k] <= 7'h00;
        end else if (fld_wr) begin
          addr_r[k] <= w_data_r[LANE*8+1 +: 7];
        end
      end
      // Test outputs take only bits that are outputs
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          test_r[k] <= 16'h0000;
        end else if (ctl_wr && wtm && wsel == 4'(k) && (|w_strb_r[1:0])) begin
          test_r[k] <= (w_data_r[15:0] & ~exp_dir_in[k]) | (test_r[k] & exp_dir_in[k]);
        end
      end
    end
  endgenerate

  // Queued work; a new request while busy waits its turn
  always_comb begin
    init_idx = 3'h0;
    for (int i = `SIOE_NUM_EXP - 1; i >= 0; i--) begin
      if (init_pend_r[i]) begin
        init_idx = 3'(i);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      init_pend_r <= 5'h00;
      rfr_pend_r <= 1'b0;
    end else begin
      if (st_r == SIOE_IDLE && |init_pend_r) begin
        init_pend_r <= (init_pend_r & ~(5'h01 << init_idx)) | init_set;
      end else begin
        init_pend_r <= init_pend_r | init_set;
      end
      if (ctl_wr && w_strb_r[3] && w_data_r[`SIOE_RFR_BIT]) begin
        rfr_pend_r <= 1'b1;
      end else if (st_r == SIOE_IDLE && !(|init_pend_r)) begin
        rfr_pend_r <= 1'b0;
      end
    end
  end

  // Output value: test data for the selected expander in test mode
  assign out_val = (tm_r && sel_r == {1'b0, exp_r}) ? test_r[exp_r] : core_out_in[exp_r];
  assign last_step = (kind_r == SIOE_SEQ_IN) ? 4'h7 : 4'h5;

  // Step table of each transaction kind
  always_comb begin
    step_cmd = '{op: SIOE_OP_WRITE, data: 8'h00, last: 1'b0};
    case (step_r)
      4'h0: step_cmd.op = SIOE_OP_START;
      4'h1: step_cmd.data = {addr_r[exp_r], 1'b0};
      4'h2: begin
        case (kind_r)
          SIOE_SEQ_OUT: step_cmd.data = `SIOE_CMD_OUT;
          SIOE_SEQ_CFG: step_cmd.data = `SIOE_CMD_CFG;
          default: step_cmd.data = `SIOE_CMD_IN;
        endcase
      end
      4'h3: begin
        if (kind_r == SIOE_SEQ_IN) begin
          step_cmd.op = SIOE_OP_START;
        end else begin
          step_cmd.data = (kind_r == SIOE_SEQ_CFG) ? exp_dir_in[exp_r][7:0] : out_val[7:0];
        end
      end
      4'h4: begin
        if (kind_r == SIOE_SEQ_IN) begin
          step_cmd.data = {addr_r[exp_r], 1'b1};
        end else begin
          step_cmd.data = (kind_r == SIOE_SEQ_CFG) ? exp_dir_in[exp_r][15:8] : out_val[15:8];
        end
      end
      4'h5: step_cmd.op = (kind_r == SIOE_SEQ_IN) ? SIOE_OP_READ : SIOE_OP_STOP;
      4'h6: begin
        step_cmd.op = SIOE_OP_READ;
        step_cmd.last = 1'b1;
      end
      default: step_cmd.op = SIOE_OP_STOP;
    endcase
  end

  // Completion when the selected expander's work ends
  assign done_set = st_r == SIOE_WAIT && eng_done && step_r == last_step && kind_r != SIOE_SEQ_OUT &&
                    sel_r == {1'b0, exp_r};

  // Sequencer: one engine command at a time
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_r <= SIOE_IDLE;
      kind_r <= SIOE_SEQ_OUT;
      exp_r <= 3'h0;
      step_r <= 4'h0;
      cmd_valid_r <= 1'b0;
      cmd_r <= '0;
      rx_lo_r <= 8'h00;
    end else begin
      case (st_r)
        SIOE_IDLE: begin
          step_r <= 4'h0;
          if (|init_pend_r) begin
            exp_r <= init_idx;
            kind_r <= SIOE_SEQ_CFG;
            st_r <= SIOE_ISSUE;
          end else if (rfr_pend_r) begin
            exp_r <= 3'h0;
            kind_r <= SIOE_SEQ_OUT;
            st_r <= SIOE_ISSUE;
          end
        end
        SIOE_ISSUE: begin
          // Offer the step, then wait for it to finish
          if (cmd_valid_r && eng_ready) begin
            cmd_valid_r <= 1'b0;
            st_r <= SIOE_WAIT;
          end else begin
            cmd_valid_r <= 1'b1;
            cmd_r <= step_cmd;
          end
        end
        SIOE_WAIT: begin
          if (eng_done) begin
            if (kind_r == SIOE_SEQ_IN && step_r == 4'h5) begin
              rx_lo_r <= eng_rdata;
            end
            step_r <= 4'h0;
            st_r <= SIOE_ISSUE;
            if (step_r != last_step) begin
              step_r <= step_r + 4'h1;
            end else if (kind_r == SIOE_SEQ_OUT) begin
              kind_r <= SIOE_SEQ_IN;
            end else if (kind_r == SIOE_SEQ_IN && exp_r != 3'(`SIOE_NUM_EXP - 1)) begin
              exp_r <= exp_r + 3'h1;
              kind_r <= SIOE_SEQ_OUT;
            end else begin
              st_r <= SIOE_IDLE;
            end
          end
        end
        default: st_r <= SIOE_IDLE;
      endcase
    end
  end

  // Pin state: outputs once written, inputs once read
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `SIOE_NUM_EXP; i++) begin
        pin_r[i] <= 16'h0000;
      end
    end else if (st_r == SIOE_WAIT && eng_done && step_r == last_step) begin
      if (kind_r == SIOE_SEQ_OUT) begin
        pin_r[exp_r] <= (out_val & ~exp_dir_in[exp_r]) | (pin_r[exp_r] & exp_dir_in[exp_r]);
      end else if (kind_r == SIOE_SEQ_IN) begin
        pin_r[exp_r] <= ({eng_rdata, rx_lo_r} & exp_dir_in[exp_r]) | (pin_r[exp_r] & ~exp_dir_in[exp_r]);
      end
    end
  end

  // SMBus byte engine on the master pins
  sioe_byte_eng u_eng (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid_r),
    .cmd_in(cmd_r),
    .cmd_ready_out(eng_ready),
    .done_out(eng_done),
    .rdata_out(eng_rdata),
    .nack_out(eng_nack),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_out(scl_out),
    .scl_oe_n_out(scl_oe_n_out),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out)
  );
endmodule
`default_nettype wire

// ===== bench/sioe_ctrl_asserts.sv
// Checker of bus and pin behaviour of the expander controller
`timescale 1ns/1ps
`default_nettype none
module sioe_ctrl_asserts (
  input wire logic core_clk_in, // Clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic sda_oe_n_out, // Data enable, low drives
  input wire logic irq_out // Interrupt
);
  logic [11:0] ra_r; // Address of the read under way
  logic ok; // Address is mapped
  // Keep the address so the answer can be judged
  always_ff @(posedge core_clk_in) begin
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  assign ok = ra_r inside {12'h430, 12'h434, 12'h438, 12'h440, 12'h444};
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_rv_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_bv_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_ctl_zero: assert property (s_axi_rvalid && ra_r == 12'h430 |-> (s_axi_rdata & 32'h41ff0000) == 32'h0)
    else $error("control reads nonzero in zero bits");
  a_sel_rsvd: assert property (s_axi_rvalid && ra_r == 12'h430 && s_axi_rdata[29:26] > 4'h4 |->
    s_axi_rdata[15:0] == 16'h0) else $error("reserved select shows pins");
  a_adr0_rsvd: assert property (s_axi_rvalid && ra_r == 12'h434 |-> (s_axi_rdata & 32'h01010101) == 32'h0)
    else $error("low address reserved bit set");
  a_adr1_rsvd: assert property (s_axi_rvalid && ra_r == 12'h438 |-> (s_axi_rdata & 32'hffffff01) == 32'h0)
    else $error("high address reserved bit set");
  a_map_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (ok ? 2'h0 : 2'h2)) else $error("bad read response");
  a_irq_reset: assert property ($rose(rst_n_in) |-> !irq_out && sda_oe_n_out)
    else $error("flag or pin active after reset");
  c_done: cover property (s_axi_rvalid && ra_r == 12'h430 && s_axi_rdata[31]);
  c_irq: cover property (irq_out);
  c_pin: cover property (!sda_oe_n_out);
endmodule
bind sioe_ctrl sioe_ctrl_asserts i_sioe_ctrl_asserts (.*);
`default_nettype wire

// ===== bench/sioe_exp_model.sv
// Behavioural expander on the pulled-up bus: acknowledges every byte
`timescale 1ns/1ps
`default_nettype none
module sioe_exp_model (
  input wire logic scl_in, // Clock line level
  input wire logic sda_in, // Data line level
  output logic pull_out // High pulls the data line low
);
  int bits = 0; // Clock rises since start or last ack
  initial pull_out = 1'b0;
  // Falling data with the clock high is a start
  always @(negedge sda_in) begin
    if (scl_in) bits = 0;
  end
  // Count bit clocks
  always @(posedge scl_in) bits = bits + 1;
  // Pull for the acknowledge slot, release after it
  always @(negedge scl_in) begin
    if (bits == 8) pull_out = 1'b1;
    else if (bits == 9) begin
      pull_out = 1'b0;
      bits = 0;
    end
  end
endmodule
`default_nettype wire

// ===== bench/sioe_ctrl_test.sv
// Self-checking bench of the expander controller
`timescale 1ns/1ps
`default_nettype none
module sioe_ctrl_test;
  logic core_clk_in, rst_n_in, sticky_rst_n_in; // Clock and resets
  logic [11:0] awaddr, araddr; // Bus addresses
  logic awvalid, wvalid, bready, arvalid, rready; // Master strobes
  logic [31:0] wdata, v; // Write data, last read word
  logic [1:0] rs; // Last read response
  wire logic awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, irq, pull; // Slave side
  wire logic [1:0] bresp, rresp; // Responses
  wire logic [31:0] rdata; // Read data
  wire logic scl = scl_oe_n; // Pulled-up clock line
  wire logic sda = sda_oe_n & ~pull; // Pulled-up data line
  int n_errors = 0, checks = 0, n; // Counters
  sioe_ctrl i_sioe_ctrl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sticky_rst_n_in(sticky_rst_n_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_out_in(80'h0), .exp_dir_in(80'h0), .scl_in(scl), .sda_in(sda), .scl_out(), .scl_oe_n_out(scl_oe_n),
    .sda_out(), .sda_oe_n_out(sda_oe_n), .irq_out(irq));
  sioe_exp_model i_sioe_exp_model (.scl_in(scl), .sda_in(sda), .pull_out(pull));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge core_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge core_clk_in);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      if (hb) check({30'h0, bresp}, 32'h0);
      @(posedge core_clk_in);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  // One bus read into v and rs
  task automatic rd(input logic [11:0] a);
    logic ha, hr;
    @(posedge core_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge core_clk_in);
      ha = arvalid && arready;
      hr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge core_clk_in);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // Look at the interrupt after it has settled
  task automatic irq_is(input logic e);
    repeat (2) @(negedge core_clk_in);
    check({31'h0, irq}, {31'h0, e});
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d errors", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Clock
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // Watchdog
  initial begin
    #(60000 * 25);
    n_errors++;
    print_verdict();
  end
  // Tests
  initial begin
    {rst_n_in, sticky_rst_n_in, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata} = 56'h0;
    repeat (12) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    sticky_rst_n_in <= 1'b1;
    for (n = 0; n < 3; n++) begin
      rd(12'h430 + 12'(4 * n));
      check(v, 32'h0);
    end
    rd(12'h448);
    check({v[31:2], rs}, 32'h2);
    $display("Test reset and unmapped done");
    wr(12'h444, 32'h1);
    wr(12'h430, 32'h10000000);
    wr(12'h438, 32'hffffffff);
    wr(12'h434, 32'hffffffff);
    rd(12'h438);
    check(v, 32'h000000fe);
    rd(12'h434);
    check(v, 32'hfefefefe);
    for (n = 0; irq !== 1'b1 && n < 40000; n++) begin
      @(negedge core_clk_in);
    end
    check({31'h0, irq}, 32'h1);
    rd(12'h430);
    check(v & 32'hffff0000, 32'h90000000);
    wr(12'h444, 32'h0);
    irq_is(1'b0);
    wr(12'h444, 32'h1);
    irq_is(1'b1);
    wr(12'h430, 32'h90000000);
    rd(12'h430);
    check(v & 32'hffff0000, 32'h10000000);
    wr(12'h440, 32'h1);
    irq_is(1'b0);
    $display("Test init and completion flag done");
    wr(12'h430, 32'h12000000);
    rd(12'h430);
    check(v & 32'hffff0000, 32'h12000000);
    wr(12'h430, 32'h1300a5c3);
    rd(12'h430);
    check(v & 32'hffff0000, 32'h12000000);
    for (n = 0; irq !== 1'b1 && n < 40000; n++) begin
      @(negedge core_clk_in);
    end
    rd(12'h430);
    check(v, 32'h9200a5c3);
    wr(12'h430, 32'h94000000);
    rd(12'h430);
    check(v, 32'h14000000);
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(12'h434);
    check(v, 32'hfefefefe);
    rd(12'h430);
    check(v, 32'h0);
    @(posedge core_clk_in);
    sticky_rst_n_in <= 1'b0;
    @(posedge core_clk_in);
    sticky_rst_n_in <= 1'b1;
    rd(12'h434);
    check(v, 32'h0);
    $display("Test test mode and resets done");
    print_verdict();
  end
endmodule
`default_nettype wire
